/* rtl/tcp_pkg.sv */
// Shared constants and types for the transceiver control pin link
package tcp_pkg;
   // -----------------------------------------------------------
   // Timing
   // -----------------------------------------------------------
   localparam int CLK_PERIOD_NS = 4;
   localparam int INIT_TIME_NS = 400;
   localparam int PWRUP_TIME_NS = 800;
   localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PWRUP_CYCLES = (PWRUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MDC_HALF = 8;
   // -----------------------------------------------------------
   // Management frame
   // -----------------------------------------------------------
   localparam int PRE_BITS = 32;
   localparam int FRAME_BITS = 64;
   localparam int TA_BIT = 46;
   localparam int DATA_BIT = 48;
   localparam logic [4:0] MOD_DEVAD = 5'h01;
   localparam logic [1:0] PRT_HI = 2'h0;
   localparam logic [1:0] OP_ADDR = 2'h0;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] IL_CLASS_9W = 2'h2;
   // -----------------------------------------------------------
   // Module management registers
   // -----------------------------------------------------------
   localparam logic [15:0] MR_CTRL = 16'h0000;
   localparam logic [15:0] MR_STATUS = 16'h0001;
   localparam logic [15:0] MR_ALARM = 16'h0002;
   localparam logic [15:0] MR_AMASK = 16'h0003;
   localparam int MC_TXOFF = 0;
   localparam int MC_LOPWR = 1;
   localparam logic [1:0] MR_CTRL_RST = 2'h0;
   localparam logic [1:0] MR_AMASK_RST = 2'h3;
   // -----------------------------------------------------------
   // Host registers
   // -----------------------------------------------------------
   localparam logic [2:0] HR_CTRL = 3'h0;
   localparam logic [2:0] HR_PINS = 3'h1;
   localparam logic [2:0] HR_CMD = 3'h2;
   localparam logic [2:0] HR_RDATA = 3'h3;
   localparam logic [2:0] HR_ISTAT = 3'h4;
   localparam logic [2:0] HR_IMASK = 3'h5;
   localparam int HC_TXOFF = 0;
   localparam int HC_LOPWR = 1;
   localparam int HC_RSTN = 2;
   localparam int HC_TRXN = 3;
   localparam int HC_IL = 4;
   localparam int HC_PRT = 6;
   localparam logic [8:0] HR_CTRL_RST = 9'h02B;
   localparam logic [3:0] HR_IMASK_RST = 4'h0;
   // -----------------------------------------------------------
   // State encodings
   // -----------------------------------------------------------
   typedef enum logic [2:0] {
      M_RESET = 3'h0, M_INIT = 3'h1, M_LOWPWR = 3'h2, M_PWRUP = 3'h3, M_READY = 3'h4
   } tcp_main_e;
   typedef enum logic [1:0] {
      S_PRE = 2'h0, S_HDR = 2'h1, S_TA = 2'h2, S_DATA = 2'h3
   } tcp_sl_e;
endpackage : tcp_pkg

/* rtl/tcp_if.sv */
// Pin bundle between host line card and transceiver module
`timescale 1ns/1ns
interface tcp_if;
   logic transmit_off_in;
   logic low_power_request;
   logic module_reset_low;
   logic prog_control_in_one;
   logic prog_control_in_two;
   logic prog_control_in_three;
   logic port_addr_bit0;
   logic port_addr_bit1;
   logic port_addr_bit2;
   logic mdc;
   logic mdio_host_o;
   logic mdio_host_oe;
   logic mdio_mod_o;
   logic mdio_mod_oe;
   logic mdio;
   logic global_alarm_low;
   logic prog_alarm_out_one;
   logic prog_alarm_out_two;
   logic prog_alarm_out_three;
   logic receive_signal_lost;
   logic module_absent_o;
   logic module_absent_oe;
   logic module_absent_flag;
   // Pull-ups on the shared data line and on the absence line
   assign mdio = mdio_mod_oe ? mdio_mod_o : (mdio_host_oe ? mdio_host_o : 1'b1);
   assign module_absent_flag = module_absent_oe ? module_absent_o : 1'b1;
   modport module_mp(
      input transmit_off_in, low_power_request, module_reset_low, prog_control_in_one,
      prog_control_in_two, prog_control_in_three, port_addr_bit0, port_addr_bit1,
      port_addr_bit2, mdc, mdio,
      output mdio_mod_o, mdio_mod_oe, global_alarm_low, prog_alarm_out_one,
      prog_alarm_out_two, prog_alarm_out_three, receive_signal_lost, module_absent_o,
      module_absent_oe
   );
   modport host_mp(
      output transmit_off_in, low_power_request, module_reset_low, prog_control_in_one,
      prog_control_in_two, prog_control_in_three, port_addr_bit0, port_addr_bit1,
      port_addr_bit2, mdc, mdio_host_o, mdio_host_oe,
      input mdio, global_alarm_low, prog_alarm_out_one, prog_alarm_out_two,
      prog_alarm_out_three, receive_signal_lost, module_absent_flag
   );
endinterface : tcp_if

/* rtl/tcp_module.sv */
// Module end: control pins, alarm pins and management slave
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ns
// Functional notes
// - Transmit-off high turns all lanes off
// - Low-power high keeps module in low power
// - Reset input low holds module in reset
// - Reset release runs initialization before operation
// - Global alarm low while any unmasked alarm bit set
// - Alarm output one shows high power done
// - Alarm output two shows module ready
// - Alarm output three shows module fault
// - Control input one low resets transceiver chip
// - Controls two/three form interlock code, 10 = 9 W
// - Loss output high on low received power
// - Inserted module pulls absent line low
// - Strapped port address selects management frames
// - Clause 45 frames, host manages, module answers
// - Host drives management clock, data shared
module tcp_module
   import tcp_pkg::*;
(
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic CE,
   input wire logic RX_POWER_LOW,
   input wire logic FAULT_IN,
   output logic TX_LANES_OFF,
   output logic LOW_POWER_MODE,
   output logic CORE_RESET,
   output logic TRX_IC_RESET,
   output logic [1:0] INTERLOCK_CODE,
   tcp_if.module_mp PINS
);
   // -----------------------------------------------------------
   // State
   // -----------------------------------------------------------
   typedef struct packed {
      logic txoff;
      logic lopwr;
      logic rst_n;
      logic c1;
      logic c2;
      logic c3;
      logic [2:0] prt;
      logic mdc;
      logic mdio;
      logic los;
      logic fault;
   } tcp_mpins_s;

   typedef struct packed {
      tcp_mpins_s s1;
      tcp_mpins_s s2;
      logic mdc_d;
      tcp_main_e main;
      logic [9:0] cnt;
      tcp_sl_e sl;
      logic [5:0] ones;
      logic [3:0] bits;
      logic [11:0] hdr;
      logic [1:0] op;
      logic [15:0] maddr;
      logic [15:0] sh;
      logic [1:0] ctrl;
      logic [1:0] alarm;
      logic [1:0] amask;
      logic mdo;
      logic mdoe;
      logic txoff;
      logic lopwr;
      logic crst;
      logic trst;
      logic [1:0] il;
      logic galn;
      logic hipwr;
      logic ready;
      logic fault;
      logic los;
      logic abs_oe;
   } tcp_mstate_s;

   tcp_mstate_s st_reg;
   tcp_mstate_s st_next;

   // -----------------------------------------------------------
   // Next state
   // -----------------------------------------------------------
   always_comb begin
      logic rise;
      logic b;
      logic lp;
      logic hit;
      logic [1:0] il;
      logic [1:0] clr;
      logic [15:0] w;
      logic [15:0] rv;
      rise = 1'b0;
      b = 1'b0;
      lp = 1'b0;
      hit = 1'b0;
      il = 2'h0;
      clr = 2'h0;
      w = 16'h0000;
      rv = 16'h0000;
      st_next = st_reg;
      // Raw pins only reach the first stage
      st_next.s1 = {PINS.transmit_off_in, PINS.low_power_request, PINS.module_reset_low,
                    PINS.prog_control_in_one, PINS.prog_control_in_two,
                    PINS.prog_control_in_three, PINS.port_addr_bit2, PINS.port_addr_bit1,
                    PINS.port_addr_bit0, PINS.mdc, PINS.mdio, RX_POWER_LOW,
                    FAULT_IN};
      st_next.s2 = st_reg.s1;
      st_next.mdc_d = st_reg.s2.mdc;
      rise = st_reg.s2.mdc & ~st_reg.mdc_d;
      b = st_reg.s2.mdio;
      lp = st_reg.s2.lopwr | st_reg.ctrl[MC_LOPWR];
      il = {st_reg.s2.c3, st_reg.s2.c2};

      // -----------------------------------------------------------
      // Power sequence
      // -----------------------------------------------------------
      unique case (st_reg.main)
         M_RESET: begin
            if (st_reg.s2.rst_n) begin
               st_next.main = M_INIT;
               st_next.cnt = 10'h000;
            end
         end
         M_INIT: begin
            st_next.cnt = st_reg.cnt + 10'h001;
            if (st_reg.cnt == 10'(INIT_CYCLES - 1)) begin
               st_next.main = M_LOWPWR;
            end
         end
         M_LOWPWR: begin
            // Power-up also waits for the 9 W interlock class
            if (!lp && il == IL_CLASS_9W) begin
               st_next.main = M_PWRUP;
               st_next.cnt = 10'h000;
            end
         end
         M_PWRUP: begin
            if (lp) begin
               st_next.main = M_LOWPWR;
            end else begin
               st_next.cnt = st_reg.cnt + 10'h001;
               if (st_reg.cnt == 10'(PWRUP_CYCLES - 1)) begin
                  st_next.main = M_READY;
               end
            end
         end
         M_READY: begin
            if (lp) begin
               st_next.main = M_LOWPWR;
            end
         end
         default: begin
            st_next.main = M_RESET;
         end
      endcase

      // -----------------------------------------------------------
      // Management slave
      // -----------------------------------------------------------
      w = {st_reg.sh[14:0], b};
      unique case (st_reg.maddr)
         MR_CTRL: rv = {14'h0000, st_reg.ctrl};
         MR_STATUS: rv = {8'h00, st_reg.il, st_reg.los, st_reg.fault, st_reg.hipwr,
                          st_reg.ready, st_reg.lopwr, st_reg.txoff};
         MR_ALARM: rv = {14'h0000, st_reg.alarm};
         MR_AMASK: rv = {14'h0000, st_reg.amask};
         default: rv = 16'h0000;
      endcase
      if (rise) begin
         unique case (st_reg.sl)
            S_PRE: begin
               if (b) begin
                  if (st_reg.ones != 6'(PRE_BITS)) begin
                     st_next.ones = st_reg.ones + 6'h01;
                  end
               end else begin
                  st_next.ones = 6'h00;
                  if (st_reg.ones == 6'(PRE_BITS)) begin
                     st_next.sl = S_HDR;
                     st_next.bits = 4'h0;
                  end
               end
            end
            S_HDR: begin
               st_next.hdr = {st_reg.hdr[10:0], b};
               st_next.bits = st_reg.bits + 4'h1;
               if (st_reg.bits == 4'hC) begin
                  hit = !st_reg.hdr[11] && st_reg.hdr[8:4] == {PRT_HI, st_reg.s2.prt}
                        && {st_reg.hdr[3:0], b} == MOD_DEVAD;
                  st_next.op = st_reg.hdr[10:9];
                  st_next.bits = 4'h0;
                  st_next.sl = hit ? S_TA : S_PRE;
                  st_next.sh = rv;
                  if (hit && st_reg.hdr[10]) begin
                     // A read of the alarm register clears it
                     if (st_reg.maddr == MR_ALARM) begin
                        clr = 2'h3;
                     end
                     if (!st_reg.hdr[9]) begin
                        st_next.maddr = st_reg.maddr + 16'h0001;
                     end
                  end
               end
            end
            S_TA: begin
               st_next.bits = st_reg.bits + 4'h1;
               if (st_reg.bits == 4'h0) begin
                  st_next.mdoe = st_reg.op[1];
                  st_next.mdo = 1'b0;
               end else begin
                  st_next.sl = S_DATA;
                  st_next.bits = 4'h0;
                  st_next.mdo = st_reg.sh[15];
               end
            end
            S_DATA: begin
               st_next.bits = st_reg.bits + 4'h1;
               st_next.sh = w;
               st_next.mdo = st_reg.sh[14];
               if (st_reg.bits == 4'hF) begin
                  st_next.sl = S_PRE;
                  st_next.mdoe = 1'b0;
                  st_next.ones = 6'h00;
                  if (st_reg.op == OP_ADDR) begin
                     st_next.maddr = w;
                  end else if (st_reg.op == OP_WRITE) begin
                     if (st_reg.maddr == MR_CTRL) begin
                        st_next.ctrl = w[1:0];
                     end
                     if (st_reg.maddr == MR_AMASK) begin
                        st_next.amask = w[1:0];
                     end
                  end
               end
            end
         endcase
      end

      // -----------------------------------------------------------
      // Alarms and pin drive
      // -----------------------------------------------------------
      // New events win over a read clear in the same cycle
      st_next.alarm = (st_reg.alarm & ~clr) | {st_reg.s2.fault, st_reg.s2.los};
      st_next.galn = ~|(st_reg.alarm & st_reg.amask);
      st_next.txoff = st_reg.s2.txoff | st_reg.ctrl[MC_TXOFF]
                      | (st_reg.main != M_READY);
      st_next.lopwr = !(st_reg.main == M_PWRUP || st_reg.main == M_READY);
      st_next.crst = st_reg.main == M_RESET;
      st_next.trst = !st_reg.s2.c1 || st_reg.main == M_RESET;
      st_next.il = il;
      st_next.hipwr = st_reg.main == M_READY;
      st_next.ready = st_reg.main == M_READY;
      st_next.fault = st_reg.s2.fault;
      st_next.los = st_reg.s2.los;
      st_next.abs_oe = 1'b1;

      if (!st_reg.s2.rst_n) begin
         st_next.main = M_RESET;
         st_next.ctrl = MR_CTRL_RST;
         st_next.alarm = 2'h0;
         st_next.amask = MR_AMASK_RST;
         st_next.sl = S_PRE;
         st_next.ones = 6'h00;
         st_next.mdoe = 1'b0;
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         st_reg <= '0;
         st_reg.amask <= MR_AMASK_RST;
         st_reg.txoff <= 1'b1;
         st_reg.lopwr <= 1'b1;
         st_reg.crst <= 1'b1;
         st_reg.trst <= 1'b1;
         st_reg.galn <= 1'b1;
         st_reg.abs_oe <= 1'b1;
      end else if (CE) begin
         st_reg <= st_next;
      end
   end

   // -----------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------
   assign TX_LANES_OFF = st_reg.txoff;
   assign LOW_POWER_MODE = st_reg.lopwr;
   assign CORE_RESET = st_reg.crst;
   assign TRX_IC_RESET = st_reg.trst;
   assign INTERLOCK_CODE = st_reg.il;
   assign PINS.mdio_mod_o = st_reg.mdo;
   assign PINS.mdio_mod_oe = st_reg.mdoe;
   assign PINS.global_alarm_low = st_reg.galn;
   assign PINS.prog_alarm_out_one = st_reg.hipwr;
   assign PINS.prog_alarm_out_two = st_reg.ready;
   assign PINS.prog_alarm_out_three = st_reg.fault;
   assign PINS.receive_signal_lost = st_reg.los;
   assign PINS.module_absent_o = 1'b0;
   assign PINS.module_absent_oe = st_reg.abs_oe;
endmodule : tcp_module

/* rtl/tcp_host.sv */
// Host end: control pin drive, alarm monitor and management master
`timescale 1ns/1ns
module tcp_host
   import tcp_pkg::*;
(
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic CE,
   input wire logic [2:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   output logic IRQ,
   tcp_if.host_mp PINS
);
   // -----------------------------------------------------------
   // State
   // -----------------------------------------------------------
   typedef struct packed {
      logic galn;
      logic a1;
      logic a2;
      logic a3;
      logic los;
      logic abs;
      logic mdio;
   } tcp_hpins_s;

   typedef struct packed {
      tcp_hpins_s s1;
      tcp_hpins_s s2;
      logic los_d;
      logic abs_d;
      logic [8:0] ctrl;
      logic busy;
      logic [5:0] idx;
      logic [3:0] ph;
      logic mdc;
      logic mdo;
      logic mdoe;
      logic [63:0] fr;
      logic [1:0] op;
      logic [15:0] rdat;
      logic [3:0] ist;
      logic [3:0] imask;
      logic irq;
      logic [31:0] rd;
   } tcp_hstate_s;

   tcp_hstate_s st_reg;
   tcp_hstate_s st_next;

   always_comb begin
      logic done;
      logic [3:0] clr;
      done = 1'b0;
      clr = 4'h0;
      st_next = st_reg;
      st_next.s1 = {PINS.global_alarm_low, PINS.prog_alarm_out_one, PINS.prog_alarm_out_two,
                    PINS.prog_alarm_out_three, PINS.receive_signal_lost,
                    PINS.module_absent_flag, PINS.mdio};
      st_next.s2 = st_reg.s1;
      st_next.los_d = st_reg.s2.los;
      st_next.abs_d = st_reg.s2.abs;
      st_next.rd = 32'h0000_0000;

      // -----------------------------------------------------------
      // Management master, clock made by division
      // -----------------------------------------------------------
      if (st_reg.busy) begin
         st_next.ph = st_reg.ph + 4'h1;
         if (st_reg.ph == 4'(MDC_HALF - 1)) begin
            st_next.mdc = 1'b1;
            if (st_reg.op[1] && st_reg.idx >= 6'(DATA_BIT)) begin
               st_next.rdat = {st_reg.rdat[14:0], st_reg.s2.mdio};
            end
         end
         if (st_reg.ph == 4'(2 * MDC_HALF - 1)) begin
            st_next.ph = 4'h0;
            st_next.mdc = 1'b0;
            st_next.idx = st_reg.idx + 6'h01;
            st_next.fr = {st_reg.fr[62:0], 1'b1};
            st_next.mdo = st_reg.fr[62];
            // Reads hand the line over from the turnaround on
            st_next.mdoe = !(st_reg.op[1] && st_reg.idx >= 6'(TA_BIT - 1));
            if (st_reg.idx == 6'(FRAME_BITS - 1)) begin
               st_next.busy = 1'b0;
               st_next.mdoe = 1'b0;
               done = 1'b1;
            end
         end
      end

      // -----------------------------------------------------------
      // Register port
      // -----------------------------------------------------------
      if (WR) begin
         unique case (ADDR)
            HR_CTRL: st_next.ctrl = WDATA[8:0];
            HR_CMD: begin
               // A command while a frame runs is dropped
               if (!st_reg.busy) begin
                  st_next.busy = 1'b1;
                  st_next.idx = 6'h00;
                  st_next.ph = 4'h0;
                  st_next.mdc = 1'b0;
                  st_next.op = WDATA[17:16];
                  st_next.fr = {32'hFFFF_FFFF, 2'h0, WDATA[17:16], PRT_HI,
                                st_reg.ctrl[HC_PRT +: 3], WDATA[22:18], 2'h2,
                                WDATA[15:0]};
                  st_next.mdo = 1'b1;
                  st_next.mdoe = 1'b1;
               end
            end
            HR_IMASK: st_next.imask = WDATA[3:0];
            default: ;
         endcase
      end
      if (RD) begin
         unique case (ADDR)
            HR_CTRL: st_next.rd = {23'h000000, st_reg.ctrl};
            HR_PINS: st_next.rd = {25'h0000000, st_reg.busy, st_reg.s2.abs, st_reg.s2.los,
                                   st_reg.s2.a3, st_reg.s2.a2, st_reg.s2.a1,
                                   !st_reg.s2.galn};
            HR_RDATA: st_next.rd = {15'h0000, st_reg.busy, st_reg.rdat};
            HR_ISTAT: begin
               st_next.rd = {28'h0000000, st_reg.ist};
               clr = 4'hF;
            end
            HR_IMASK: st_next.rd = {28'h0000000, st_reg.imask};
            default: st_next.rd = 32'h0000_0000;
         endcase
      end
      // Events win over the read clear
      st_next.ist = (st_reg.ist & ~clr) | {done, st_reg.s2.abs ^ st_reg.abs_d,
                    st_reg.s2.los & ~st_reg.los_d, !st_reg.s2.galn};
      st_next.irq = |(st_next.ist & st_next.imask);
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         st_reg <= '0;
         st_reg.s1.galn <= 1'b1;
         st_reg.s2.galn <= 1'b1;
         st_reg.s1.abs <= 1'b1;
         st_reg.s2.abs <= 1'b1;
         st_reg.abs_d <= 1'b1;
         st_reg.ctrl <= HR_CTRL_RST;
         st_reg.imask <= HR_IMASK_RST;
      end else if (CE) begin
         st_reg <= st_next;
      end
   end

   assign RDATA = st_reg.rd;
   assign IRQ = st_reg.irq;
   assign PINS.transmit_off_in = st_reg.ctrl[HC_TXOFF];
   assign PINS.low_power_request = st_reg.ctrl[HC_LOPWR];
   assign PINS.module_reset_low = st_reg.ctrl[HC_RSTN];
   assign PINS.prog_control_in_one = st_reg.ctrl[HC_TRXN];
   assign PINS.prog_control_in_two = st_reg.ctrl[HC_IL];
   assign PINS.prog_control_in_three = st_reg.ctrl[HC_IL + 1];
   assign PINS.port_addr_bit0 = st_reg.ctrl[HC_PRT];
   assign PINS.port_addr_bit1 = st_reg.ctrl[HC_PRT + 1];
   assign PINS.port_addr_bit2 = st_reg.ctrl[HC_PRT + 2];
   assign PINS.mdc = st_reg.mdc;
   assign PINS.mdio_host_o = st_reg.mdo;
   assign PINS.mdio_host_oe = st_reg.mdoe;
endmodule : tcp_host

/* sim/tcp_assertions.sv */
// Concurrent checks on the pins between host and module ends
`timescale 1ns/1ns
module tcp_assertions (
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic module_reset_low,
   input wire logic low_power_request,
   input wire logic mdc,
   input wire logic mdio_host_oe,
   input wire logic mdio_mod_oe,
   input wire logic global_alarm_low,
   input wire logic prog_alarm_out_one,
   input wire logic prog_alarm_out_two,
   input wire logic module_absent_flag
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!ARST_N);
   sequence mdc_high;
      mdc [*8] ##1 !mdc;
   endsequence
   a_absent_low: assert property (module_absent_flag == 1'b0)
      else $error("absent line not low");
   a_ready_pair: assert property (prog_alarm_out_one == prog_alarm_out_two)
      else $error("power done and ready differ");
   a_reset_clears: assert property (!module_reset_low [*5] |-> !prog_alarm_out_two)
      else $error("ready during reset");
   a_lowpwr_holds: assert property (low_power_request [*5] |-> !prog_alarm_out_one)
      else $error("power done in low power");
   // Ready may only rise after a full init and power-up span
   a_ready_delay: assert property ($rose(prog_alarm_out_two) |->
      $past(module_reset_low, 290) && !$past(low_power_request, 190))
      else $error("ready too early");
   // Synchronisers forbid an instant reaction to a pin change
   a_reset_sync: assert property ($fell(module_reset_low) && prog_alarm_out_two |->
      prog_alarm_out_two [*2] ##[1:3] !prog_alarm_out_two)
      else $error("reset reaction latency");
   a_oe_exclusive: assert property (!(mdio_mod_oe && mdio_host_oe))
      else $error("both ends drive data");
   a_mdc_shape: assert property ($rose(mdc) |-> mdc_high)
      else $error("clock high phase wrong");
   a_alarm_reset: assert property (!module_reset_low [*6] |-> global_alarm_low)
      else $error("alarm during reset");
endmodule : tcp_assertions

/* sim/tcp_test.sv */
// Self-checking bench joining the host end to the module end
`timescale 1ns/1ns
module tcp_test
   import tcp_pkg::*;
();
   logic CLK, ARST_N, CE, RX_POWER_LOW, FAULT_IN, WR, RD, IRQ;
   logic TX_LANES_OFF, LOW_POWER_MODE, CORE_RESET, TRX_IC_RESET;
   logic [1:0] INTERLOCK_CODE;
   logic [2:0] ADDR;
   logic [31:0] WDATA, RDATA, d;
   int err_total = 0;
   int tests_run = 0;
   tcp_if i_tcp_if();
   tcp_module i_tcp_module(.CLK, .ARST_N, .CE, .RX_POWER_LOW, .FAULT_IN, .TX_LANES_OFF,
      .LOW_POWER_MODE, .CORE_RESET, .TRX_IC_RESET, .INTERLOCK_CODE, .PINS(i_tcp_if.module_mp));
   tcp_host i_tcp_host(.CLK, .ARST_N, .CE, .ADDR, .WDATA, .WR, .RD, .RDATA, .IRQ,
      .PINS(i_tcp_if.host_mp));
   tcp_assertions i_tcp_assertions(.CLK, .ARST_N, .module_reset_low(i_tcp_if.module_reset_low),
      .low_power_request(i_tcp_if.low_power_request), .mdc(i_tcp_if.mdc),
      .mdio_host_oe(i_tcp_if.mdio_host_oe), .mdio_mod_oe(i_tcp_if.mdio_mod_oe),
      .global_alarm_low(i_tcp_if.global_alarm_low),
      .prog_alarm_out_one(i_tcp_if.prog_alarm_out_one),
      .prog_alarm_out_two(i_tcp_if.prog_alarm_out_two),
      .module_absent_flag(i_tcp_if.module_absent_flag));
   task end_of_test;
      $display("mismatches %0d of %0d checks", err_total, tests_run);
      if (err_total == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         err_total++;
         $display("[FAIL] %s exp %h got %h", n, e, s);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(negedge CLK);
   endtask : cyc
   task wr(input logic [2:0] a, input logic [31:0] v);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= v;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
   endtask : wr
   task rd(input logic [2:0] a, output logic [31:0] v);
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      @(negedge CLK);
      v = RDATA;
   endtask : rd
   // Polls busy; a frame takes about a thousand cycles
   task frame(input logic [31:0] c, output logic [31:0] v);
      wr(HR_CMD, c);
      for (int i = 0; i < 1000; i++) begin
         rd(HR_RDATA, v);
         if (v[16] === 1'b0)
            break;
      end
      chk("busy", v[16], 1'b0);
   endtask : frame
   initial begin
      CLK = 1'b0;
      forever #2 CLK = ~CLK;
   end
   initial begin
      #60000;
      err_total++;
      end_of_test;
   end
   initial begin
      {ARST_N, RX_POWER_LOW, FAULT_IN, WR, RD, ADDR, WDATA} = '0;
      CE = 1'b1;
      repeat (4) @(posedge CLK);
      ARST_N <= 1'b1;
      cyc(1);
      chk("lanes", TX_LANES_OFF, 1'b1);
      chk("lowpwr", LOW_POWER_MODE, 1'b1);
      chk("core rst", CORE_RESET, 1'b1);
      // Host synchronisers leave reset showing the pull-up level of the absence line
      cyc(2);
      rd(HR_PINS, d);
      chk("pins", d[6:0], 7'h00);
      wr(HR_CTRL, 32'h0000016C);
      cyc(50);
      chk("init", CORE_RESET, 1'b0);
      chk("early rdy", i_tcp_if.prog_alarm_out_two, 1'b0);
      cyc(400);
      rd(HR_PINS, d);
      chk("pins rdy", d[6:0], 7'h06);
      chk("lanes on", TX_LANES_OFF, 1'b0);
      chk("interlock", INTERLOCK_CODE, 2'h2);
      chk("trx", TRX_IC_RESET, 1'b0);
      @(posedge CLK);
      FAULT_IN <= 1'b1;
      RX_POWER_LOW <= 1'b1;
      cyc(10);
      chk("fault", i_tcp_if.prog_alarm_out_three, 1'b1);
      chk("los", i_tcp_if.receive_signal_lost, 1'b1);
      chk("galarm", i_tcp_if.global_alarm_low, 1'b0);
      chk("irq masked", IRQ, 1'b0);
      wr(HR_IMASK, 32'h00000002);
      cyc(2);
      chk("irq", IRQ, 1'b1);
      rd(HR_ISTAT, d);
      chk("istat", d[1], 1'b1);
      cyc(2);
      chk("irq clr", IRQ, 1'b0);
      frame(32'h00040001, d);
      frame(32'h00070000, d);
      chk("status", d[15:0], 16'h00BC);
      frame(32'h00040002, d);
      frame(32'h00060000, d);
      chk("alarm", d[15:0], 16'h0003);
      frame(32'h00050000, d);
      chk("galarm masked", i_tcp_if.global_alarm_low, 1'b1);
      frame(32'h00070000, d);
      chk("amask", d[15:0], 16'h0000);
      // Wrong device address: nobody answers, so the pull-up is read back
      frame(32'h000B0000, d);
      chk("refused", d[15:0], 16'hFFFF);
      wr(HR_CTRL, 32'h00000165);
      cyc(10);
      chk("tx off", TX_LANES_OFF, 1'b1);
      chk("trx rst", TRX_IC_RESET, 1'b1);
      wr(HR_CTRL, 32'h00000161);
      cyc(10);
      chk("reset", CORE_RESET, 1'b1);
      wr(HR_CTRL, 32'h0000016E);
      cyc(450);
      chk("lp hold", LOW_POWER_MODE, 1'b1);
      chk("no pwr", i_tcp_if.prog_alarm_out_one, 1'b0);
      rd(3'h7, d);
      chk("unmapped", d, 32'h00000000);
      end_of_test;
   end
endmodule : tcp_test
